// *** misc_timer_pkg.sv ***
// misc_timer_pkg: register map, field positions, reset values and divider widths
// of the miscellaneous timer unit.
// assumes: imported whole by misc_timer_chain, misc_timer_unit and tb_misc_timer_unit; ext_irq_trigger does not import it.
package misc_timer_pkg;

  // ----------------------------------------------------------------------
  // register map (printed offsets are word indices, byte address = 4 * index)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 32;
  localparam logic [15:0] CTRL_INDEX  = 16'h0008;
  localparam logic [15:0] COUNT_INDEX = 16'h0009;
  localparam logic [15:0] WDOG_INDEX  = 16'h3FF0;
  localparam logic [15:0] CTRL_ADDR   = {CTRL_INDEX[13:0], 2'b00};
  localparam logic [15:0] COUNT_ADDR  = {COUNT_INDEX[13:0], 2'b00};
  localparam logic [15:0] WDOG_ADDR   = {WDOG_INDEX[13:0], 2'b00};

  // ----------------------------------------------------------------------
  // timer_ctrl_status fields
  // ----------------------------------------------------------------------
  localparam int         WRAP_FLAG_BIT     = 7;
  localparam int         PERIODIC_FLAG_BIT = 6;
  localparam int         WRAP_IE_BIT       = 5;
  localparam int         PERIODIC_IE_BIT   = 4;
  localparam int         EDGE_ONLY_BIT     = 3;
  localparam int         RATE_HI_BIT       = 1;
  localparam int         RATE_LO_BIT       = 0;
  localparam int         WDOG_CLEAR_BIT    = 0;
  localparam logic [7:0] CTRL_RESET        = 8'h03;

  // ----------------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------------
  localparam int PRESCALE_DIV = 4;
  localparam int PRESCALE_W   = 2;
  localparam int RIPPLE_W     = 8;
  localparam int DIVIDER_W    = 4;
  localparam int RATE_CNT_W   = 3;
  localparam int WDOG_CNT_W   = 3;

  // ----------------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : misc_timer_pkg

// *** misc_timer_chain.sv ***
// misc_timer_chain: bus clock prescaler, 8-bit wrap counter, 4-stage divider
// and periodic rate selector.
// assumes: aclk is the bus clock; rate_sel comes from logic on the same clock.
`timescale 1ns/1ps
module misc_timer_chain
  import misc_timer_pkg::*;
#(
  parameter int PRESC_DIV = PRESCALE_DIV,
  parameter int COUNT_W   = RIPPLE_W,
  parameter int DIV_W     = DIVIDER_W
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [1:0]         rate_sel,
  output logic      [COUNT_W-1:0] count,
  output logic                    wrap_pulse,
  output logic                    periodic_pulse
);

  logic [PRESCALE_W-1:0] presc;
  logic [DIV_W-1:0]      divider;
  logic [RATE_CNT_W-1:0] rate_cnt;
  wire                   presc_tick;
  wire                   wrap_now;
  wire                   base_tick;
  wire  [RATE_CNT_W-1:0] rate_mask;

  // selected rate = base / 2**rate_sel
  function automatic logic [RATE_CNT_W-1:0] mask_of(input logic [1:0] sel);
    logic [RATE_CNT_W-1:0] m;
    m = '0;
    for (int i = 0; i < RATE_CNT_W; i++) begin
      if (i < int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : mask_of

  assign presc_tick = (presc == PRESCALE_W'(PRESC_DIV - 1));
  assign wrap_now   = presc_tick && (count == {COUNT_W{1'b1}});
  assign base_tick  = wrap_now && (divider == {DIV_W{1'b1}});
  assign rate_mask  = mask_of(rate_sel);
  assign periodic_pulse = base_tick && ((rate_cnt & rate_mask) == rate_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc      <= '0;
      count      <= '0;
      divider    <= '0;
      rate_cnt   <= '0;
      wrap_pulse <= 1'b0;
    end else begin
      presc      <= presc_tick ? '0 : presc + 1'b1;
      count      <= presc_tick ? count + 1'b1 : count;
      divider    <= wrap_now ? divider + 1'b1 : divider;
      rate_cnt   <= base_tick ? rate_cnt + 1'b1 : rate_cnt;
      wrap_pulse <= wrap_now;
    end
  end

endmodule : misc_timer_chain

// *** ext_irq_trigger.sv ***
// ext_irq_trigger: external interrupt line conditioning with a falling edge latch.
// assumes: line_n is an asynchronous pin; ack is a one-cycle pulse on aclk.
`timescale 1ns/1ps
module ext_irq_trigger (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic line_n,
  input  wire logic edge_only,
  input  wire logic ack,
  output logic      request
);

  logic meta;
  logic line_sync;
  logic line_prev;
  logic edge_latch;
  wire  fall;

  assign fall = line_prev && !line_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta       <= 1'b1;
      line_sync  <= 1'b1;
      line_prev  <= 1'b1;
      edge_latch <= 1'b0;
    end else begin
      meta       <= line_n;
      line_sync  <= meta;
      line_prev  <= line_sync;
      // a new edge in the ack cycle is kept
      edge_latch <= fall ? 1'b1 : (ack ? 1'b0 : edge_latch);
    end
  end

  // level sensitivity only when edge_only is clear
  assign request = edge_latch || (!edge_only && !line_sync);

endmodule : ext_irq_trigger

// *** misc_timer_unit.sv ***
// misc_timer_unit: AXI4-Lite register slave, flags, interrupt request,
// liveness watchdog and external interrupt option of the timer unit.
// assumes: aclk is the bus clock; wdog_reset is fed to the chip's internal
// reset path, which in turn drives aresetn of this block.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - bus clock divided by four clocks the 8-bit counter, wrapping at E/1024
// - wrap flag sets when counter goes from all ones to zero
// - timer interrupt while wrap flag and its enable bit 5 are set
// - writing zero to the wrap flag bit clears it
// - writing zero to the periodic flag bit clears it
// - 4-stage divider after counter gives periodic base at E/16384
// - two rate bits pick base divided by 1, 2, 4 or 8
// - periodic flag sets once per period; interrupt while flag and enable set
// - watchdog counts periodic ticks by eight; timeout no sooner than seven periods
// - timeout issues internal chip reset; CPU then fetches reset vector
// - writing zero to bit 0 of index 3FF0 restarts watchdog
// - watchdog always enabled, also counts during wait mode
// - edge-only bit set: falling edge only; clear: low level and edge
// - counter readable at index 09, read-only, cleared by reset
// - both timer sources share one interrupt vector request line
// - watchdog reset goes through internal reset path, mode kept
module misc_timer_unit
  import misc_timer_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic      [DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // external interrupt pin and its service acknowledge
  input  wire logic              ext_irq_n,
  input  wire logic              ext_irq_ack,
  // requests toward the cpu and the reset controller
  output logic                   timer_irq,
  output logic                   ext_irq_req,
  output logic                   wdog_reset
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                  aw_held;
  logic [ADDR_W-1:0]     aw_addr_q;
  logic                  w_held;
  logic [DATA_W-1:0]     w_data_q;
  logic [3:0]            w_strb_q;

  logic                  wrap_flag;
  logic                  periodic_flag;
  logic                  wrap_irq_enable;
  logic                  periodic_irq_enable;
  logic                  ext_line_edge_only;
  logic                  periodic_rate_sel_hi;
  logic                  periodic_rate_sel_lo;
  logic [WDOG_CNT_W-1:0] wdog_count;

  logic [RIPPLE_W-1:0]   timer_count_view;
  logic                  wrap_pulse;
  logic                  periodic_pulse;

  // ----------------------------------------------------------------------
  // shared decode
  // ----------------------------------------------------------------------
  // one place decides which byte addresses answer okay, for reads and writes alike
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return (addr == CTRL_ADDR) || (addr == COUNT_ADDR) || (addr == WDOG_ADDR);
  endfunction : is_mapped

  // status flag: a hardware set beats a same-cycle software clear,
  // and only a written zero clears, so a written one leaves the flag alone
  function automatic logic flag_next(input logic set, input logic clear, input logic cur);
    logic nxt;
    nxt = cur;
    if (clear) begin
      nxt = 1'b0;
    end
    if (set) begin
      nxt = 1'b1;
    end
    return nxt;
  endfunction : flag_next

  // ----------------------------------------------------------------------
  // write channel: address and data accepted in either order
  // ----------------------------------------------------------------------
  wire                   aw_take;
  wire                   w_take;
  wire                   have_aw;
  wire                   have_w;
  wire                   wr_fire;
  wire  [ADDR_W-1:0]     wr_addr;
  wire  [DATA_W-1:0]     wr_data;
  wire  [3:0]            wr_strb;
  wire                   wr_hit;
  wire                   wr_ctrl;
  wire                   wdog_clear;

  // one write in flight: no new address or data while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign have_aw       = aw_held || aw_take;
  assign have_w        = w_held || w_take;
  assign wr_fire       = have_aw && have_w && !s_axi_bvalid;
  assign wr_addr       = aw_held ? aw_addr_q : s_axi_awaddr;
  assign wr_data       = w_held ? w_data_q : s_axi_wdata;
  assign wr_strb       = w_held ? w_strb_q : s_axi_wstrb;

  assign wr_hit     = is_mapped(wr_addr);
  assign wr_ctrl    = wr_fire && (wr_addr == CTRL_ADDR) && wr_strb[0];
  // only a zero in bit 0 restarts the watchdog; a one is ignored
  assign wdog_clear = wr_fire && (wr_addr == WDOG_ADDR) && wr_strb[0]
                      && !wr_data[WDOG_CLEAR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
      w_held    <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      aw_held   <= wr_fire ? 1'b0 : (aw_take ? 1'b1 : aw_held);
      aw_addr_q <= aw_take ? s_axi_awaddr : aw_addr_q;
      w_held    <= wr_fire ? 1'b0 : (w_take ? 1'b1 : w_held);
      w_data_q  <= w_take ? s_axi_wdata : w_data_q;
      w_strb_q  <= w_take ? s_axi_wstrb : w_strb_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  wire                   ar_take;
  wire  [7:0]            ctrl_view;
  wire  [DATA_W-1:0]     rd_value;
  wire                   rd_hit;
  wire                   rd_ctrl;
  wire                   rd_count;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // bit 2 is unused and reads as zero
  assign ctrl_view = {wrap_flag, periodic_flag, wrap_irq_enable, periodic_irq_enable,
                      ext_line_edge_only, 1'b0, periodic_rate_sel_hi, periodic_rate_sel_lo};
  assign rd_ctrl   = (s_axi_araddr == CTRL_ADDR);
  assign rd_count  = (s_axi_araddr == COUNT_ADDR);
  assign rd_hit    = is_mapped(s_axi_araddr);
  // the watchdog restart address is write-only and reads as zero
  assign rd_value  = rd_ctrl  ? {24'h00_0000, ctrl_view} :
                     rd_count ? {24'h00_0000, timer_count_view} :
                     '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------------
  misc_timer_chain #(
    .PRESC_DIV (PRESCALE_DIV),
    .COUNT_W   (RIPPLE_W),
    .DIV_W     (DIVIDER_W)
  ) chain (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .rate_sel       ({periodic_rate_sel_hi, periodic_rate_sel_lo}),
    .count          (timer_count_view),
    .wrap_pulse     (wrap_pulse),
    .periodic_pulse (periodic_pulse)
  );

  // ----------------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------------
  wire next_wrap_flag;
  wire next_periodic_flag;

  // a hardware set in the clear cycle wins; writing one changes nothing
  assign next_wrap_flag     = flag_next(wrap_pulse,
                                        wr_ctrl && !wr_data[WRAP_FLAG_BIT],
                                        wrap_flag);
  assign next_periodic_flag = flag_next(periodic_pulse,
                                        wr_ctrl && !wr_data[PERIODIC_FLAG_BIT],
                                        periodic_flag);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_flag            <= CTRL_RESET[WRAP_FLAG_BIT];
      periodic_flag        <= CTRL_RESET[PERIODIC_FLAG_BIT];
      wrap_irq_enable      <= CTRL_RESET[WRAP_IE_BIT];
      periodic_irq_enable  <= CTRL_RESET[PERIODIC_IE_BIT];
      ext_line_edge_only   <= CTRL_RESET[EDGE_ONLY_BIT];
      periodic_rate_sel_hi <= CTRL_RESET[RATE_HI_BIT];
      periodic_rate_sel_lo <= CTRL_RESET[RATE_LO_BIT];
    end else begin
      wrap_flag     <= next_wrap_flag;
      periodic_flag <= next_periodic_flag;
      if (wr_ctrl) begin
        wrap_irq_enable      <= wr_data[WRAP_IE_BIT];
        periodic_irq_enable  <= wr_data[PERIODIC_IE_BIT];
        ext_line_edge_only   <= wr_data[EDGE_ONLY_BIT];
        // a rate change mid-period can shorten the next watchdog window
        periodic_rate_sel_hi <= wr_data[RATE_HI_BIT];
        periodic_rate_sel_lo <= wr_data[RATE_LO_BIT];
      end
    end
  end

  // shared vector: either enabled source raises the one request
  assign timer_irq = (wrap_flag && wrap_irq_enable)
                     || (periodic_flag && periodic_irq_enable);

  // ----------------------------------------------------------------------
  // liveness watchdog
  // ----------------------------------------------------------------------
  wire wdog_at_last;
  wire wdog_expire;

  // the eighth tick after a restart expires, so the window is seven to eight periods
  assign wdog_at_last = (wdog_count == {WDOG_CNT_W{1'b1}});

  // no enable and no wait input: counts whenever the clock runs
  assign wdog_expire  = periodic_pulse && wdog_at_last && !wdog_clear;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_count <= '0;
      wdog_reset <= 1'b0;
    end else begin
      // a restart in the same cycle as a tick wins over the tick
      if (wdog_clear) begin
        wdog_count <= '0;
      end else if (periodic_pulse) begin
        wdog_count <= wdog_count + 1'b1;
      end
      // one-cycle request into the internal reset path, operating mode untouched
      wdog_reset <= wdog_expire;
    end
  end

  // ----------------------------------------------------------------------
  // external interrupt option
  // ----------------------------------------------------------------------
  ext_irq_trigger ext_trigger (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .line_n    (ext_irq_n),
    .edge_only (ext_line_edge_only),
    .ack       (ext_irq_ack),
    .request   (ext_irq_req)
  );

endmodule : misc_timer_unit

// *** misc_timer_unit_properties.sv ***
// misc_timer_unit_properties: port checks of the timer unit bus and requests.
// assumes: bound to misc_timer_unit, one clock domain on aclk.
`timescale 1ns/1ps
module misc_timer_unit_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_n,
  input wire logic ext_irq_ack,
  input wire logic timer_irq,
  input wire logic ext_irq_req,
  input wire logic wdog_reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // sequences
  // ----
  sequence s_fall;
    $fell(ext_irq_n) ##1 (!ext_irq_n && !ext_irq_ack) [*4];
  endsequence
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ----
  // properties
  // ----
  property p_aw_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_write_answer; s_write_taken |=> s_axi_bvalid; endproperty
  property p_b_release; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_r_release; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_wdog_pulse; wdog_reset |=> !wdog_reset; endproperty
  property p_ext_fall; s_fall |-> ext_irq_req; endproperty
  // reset itself must quiet every request, so this one is not disabled by it
  property p_reset_quiet;
    @(posedge aclk) disable iff (1'b0) !aresetn |=> !timer_irq && !wdog_reset && !ext_irq_req;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("write accepted while response pending");
  a_ar_refuse: assert property (p_ar_refuse) else $error("read accepted while data pending");
  a_read_answer: assert property (p_read_answer) else $error("read data late");
  a_write_answer: assert property (p_write_answer) else $error("write response late");
  a_b_release: assert property (p_b_release) else $error("write response not released");
  a_r_release: assert property (p_r_release) else $error("read data not released");
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("watchdog reset wider than one cycle");
  a_ext_fall: assert property (p_ext_fall) else $error("falling edge not requested");
  a_reset_quiet: assert property (p_reset_quiet) else $error("request active in reset");
endmodule : misc_timer_unit_properties

bind misc_timer_unit misc_timer_unit_properties chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .ext_irq_n, .ext_irq_ack, .timer_irq, .ext_irq_req, .wdog_reset);

// *** tb_misc_timer_unit.sv ***
// tb_misc_timer_unit: self-checking bench of the timer unit over axi4-lite.
// assumes: misc_timer_pkg and the design files are compiled first.
`timescale 1ns/1ps
module tb_misc_timer_unit;
  import misc_timer_pkg::*;
  logic              aclk, aresetn, ext_irq_n, ext_irq_ack;
  logic              s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              timer_irq, ext_irq_req, wdog_reset;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  int                n_mismatch, tests_run;
  logic              wdog_seen = 1'b0;

  misc_timer_unit dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
    .ext_irq_n, .ext_irq_ack, .timer_irq, .ext_irq_req, .wdog_reset);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // the watchdog pulse lasts one cycle, so it is latched for the later checks
  always @(posedge aclk) begin
    if (wdog_reset === 1'b1) begin
      wdog_seen <= 1'b1;
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : check

  // readiness is sampled mid-cycle, where it already equals its value at the next edge
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    int   i;
    logic aw, w, b;
    logic [1:0] br;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'b1;
    b = 1'b0;
    for (i = 0; i < 20 && !b; i++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    if (!b) begin
      check("write answer", 1, 0);
      finish_test();
    end
    check("bresp", er, br);
  endtask : bus_write

  task automatic bus_read(input logic [15:0] a, input logic [1:0] er, output logic [31:0] rd);
    int   i;
    logic ar, r;
    logic [1:0] rr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    r = 1'b0;
    for (i = 0; i < 20 && !r; i++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    if (!r) begin
      check("read answer", 1, 0);
      finish_test();
    end
    check("rresp", er, rr);
  endtask : bus_read

  task automatic wait_irq(input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge aclk);
      if (timer_irq === 1'b1) break;
    end
    @(posedge aclk);
    if (n == lim) begin
      check("timer request", 1, 0);
      finish_test();
    end
  endtask : wait_irq
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    logic [31:0] rd;
    bus_read(CTRL_ADDR, RESP_OKAY, rd);
    check("ctrl reset", {24'h00_0000, CTRL_RESET}, rd);
    bus_write(COUNT_ADDR, 8'hFF, RESP_OKAY);
    bus_read(COUNT_ADDR, RESP_OKAY, rd);
    check("count near zero", 1, rd < 32'h0000_0010);
    bus_read(16'h0100, RESP_SLVERR, rd);
    check("unmapped read data", 0, rd);
    bus_write(16'h0100, 8'h00, RESP_SLVERR);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_wrap;
    int n;
    logic [31:0] rd;
    bus_write(WDOG_ADDR, 8'h00, RESP_OKAY);
    bus_write(CTRL_ADDR, 8'h20, RESP_OKAY);
    wait_irq(1100, n);
    bus_read(CTRL_ADDR, RESP_OKAY, rd);
    check("wrap flag", 32'h0000_00A0, rd);
    bus_write(CTRL_ADDR, 8'hA0, RESP_OKAY);
    bus_read(CTRL_ADDR, RESP_OKAY, rd);
    check("flag after one", 32'h0000_00A0, rd);
    bus_write(CTRL_ADDR, 8'h20, RESP_OKAY);
    @(negedge aclk);
    check("request after clear", 0, timer_irq);
    wait_irq(1100, n);
    check("wrap interval", 1, n > 990 && n <= 1024);
    bus_write(CTRL_ADDR, 8'h00, RESP_OKAY);
    $display("test wrap flag done");
  endtask : t_wrap

  task automatic t_periodic;
    int n;
    logic [31:0] rd;
    bus_write(WDOG_ADDR, 8'h00, RESP_OKAY);
    bus_write(CTRL_ADDR, 8'h10, RESP_OKAY);
    wait_irq(16500, n);
    bus_read(CTRL_ADDR, RESP_OKAY, rd);
    check("periodic flag", 1, rd[PERIODIC_FLAG_BIT]);
    bus_write(WDOG_ADDR, 8'h00, RESP_OKAY);
    bus_write(CTRL_ADDR, 8'h11, RESP_OKAY);
    wait_irq(33000, n);
    bus_write(WDOG_ADDR, 8'h00, RESP_OKAY);
    bus_write(CTRL_ADDR, 8'h11, RESP_OKAY);
    wait_irq(33000, n);
    check("periodic interval", 1, n > 32700 && n <= 32768);
    check("no watchdog reset", 0, wdog_seen);
    bus_write(WDOG_ADDR, 8'h00, RESP_OKAY);
    bus_write(CTRL_ADDR, 8'h00, RESP_OKAY);
    $display("test periodic done");
  endtask : t_periodic

  task automatic t_ext(input logic [7:0] mode, input logic after_ack);
    bus_write(CTRL_ADDR, mode, RESP_OKAY);
    ext_irq_n <= 1'b0;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    check("pin request", 1, ext_irq_req);
    @(posedge aclk);
    ext_irq_ack <= 1'b1;
    @(posedge aclk);
    ext_irq_ack <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check("request after ack", after_ack, ext_irq_req);
    @(posedge aclk);
    ext_irq_n <= 1'b1;
    repeat (4) @(posedge aclk);
    $display("test external line done");
  endtask : t_ext

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    aresetn = 1'b0;
    ext_irq_n = 1'b1;
    ext_irq_ack = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_wrap();
    t_periodic();
    t_ext(8'h00, 1'b1);
    t_ext(8'h08, 1'b0);
    check("watchdog quiet", 0, wdog_seen);
    finish_test();
  end
endmodule : tb_misc_timer_unit
